// ### ppses_accum.sv
// Purpose: One 32-bit statistics counter with software load
// Assumes: Increment arrives registered from the event selector
// Notes:   A software load in the same cycle drops that increment
`timescale 1ns/1ps
`include "ppses_defs.svh"

module ppses_accum (
    input  wire logic                     clk,
    input  wire logic                     nrst,
    input  wire logic                     ce,
    input  wire logic                     load,
    input  wire logic [`PPSES_DATA_W-1:0] load_data,
    input  wire logic [`PPSES_INC_W-1:0]  inc,
    output logic      [`PPSES_DATA_W-1:0] count
);

    ppses_pkg::ppses_accum_s st_ff;
    ppses_pkg::ppses_accum_s nxt_st;

    always_comb begin
        nxt_st = st_ff;
        if (load) begin
            nxt_st.count = load_data;
        end else begin
            nxt_st.count = st_ff.count + {25'h0000000, inc};
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_ff.count <= `PPSES_COUNT_RST;
        end else if (ce) begin
            st_ff <= nxt_st;
        end
    end

    assign count = st_ff.count;

    count_step_a: assert property (@(posedge clk) disable iff (!nrst)
        ce && !load |=> count == $past(count) + {25'h0000000, $past(inc)})
        else $error("counter did not advance by the increment");

    freeze_hold_a: assert property (@(posedge clk) disable iff (!nrst)
        !ce |=> $stable(count))
        else $error("counter moved while clock enable was low");

endmodule

// ### ppses_defs.svh
// Purpose: Offsets, field positions, reset values and widths of the event select block
// Assumes: Bit n of a field position is bit n of the 32-bit register word
// Notes:   Counter k fields sit at k * stride plus the field position
`ifndef PPSES_DEFS_SVH
`define PPSES_DEFS_SVH

`define PPSES_ADDR_W       16
`define PPSES_DATA_W       32
`define PPSES_INC_W        7
`define PPSES_TYPE_W       3

`define PPSES_CTRL_OFS     16'h0024
`define PPSES_CTR2_OFS     16'h0028
`define PPSES_CTR3_OFS     16'h002C

`define PPSES_CTRL_RST     32'h0000_0000
`define PPSES_COUNT_RST    32'h0000_0000
`define PPSES_CTRL_MASK    32'hE08F_E08F

`define PPSES_CTR_STRIDE   16
`define PPSES_PRIO3_POS    0
`define PPSES_PRIO2_POS    1
`define PPSES_PRIO1_POS    2
`define PPSES_PRIO0_POS    3
`define PPSES_DIR_POS      7
`define PPSES_TYPE_LSB     13

`endif

// ### ppses_match.sv
// Purpose: Turns one cycle of port events into an increment for one counter
// Assumes: Event inputs are valid for one cycle each
// Notes:   Control symbols carry no priority; any priority select enables them
`timescale 1ns/1ps
`include "ppses_defs.svh"

module ppses_match (
    input  wire logic [2:0]              ev_type,
    input  wire logic [3:0]              prio_sel,
    input  wire logic                    dir_sel,
    input  wire logic                    pkt_valid,
    input  wire logic                    pkt_dir,
    input  wire logic [1:0]              pkt_prio,
    input  wire logic                    pkt_multicast,
    input  wire logic                    pkt_request,
    input  wire logic                    pkt_maint,
    input  wire logic                    pkt_retried,
    input  wire logic [`PPSES_INC_W-1:0] pkt_words,
    input  wire logic                    sym_valid,
    input  wire logic                    sym_dir,
    input  wire logic                    sym_retry,
    input  wire logic                    sym_multicast,
    output logic      [`PPSES_INC_W-1:0] inc
);

    logic pkt_ok;
    logic sym_ok;
    logic uni_ok;
    logic mc_ok;

    // Retried packets never count; direction and priority gate every packet
    assign pkt_ok = pkt_valid && !pkt_retried && (pkt_dir == dir_sel) && prio_sel[pkt_prio];
    assign sym_ok = sym_valid && (sym_dir == dir_sel) && (|prio_sel);
    assign uni_ok = pkt_ok && !pkt_multicast;
    assign mc_ok  = pkt_ok && pkt_multicast;

    always_comb begin
        inc = 7'h00;
        case (ppses_pkg::ppses_type_e'(ev_type))
            ppses_pkg::type_uni_req: begin
                if (uni_ok && pkt_request && !pkt_maint) inc = 7'h01;
            end
            ppses_pkg::type_uni_all: begin
                if (uni_ok) inc = 7'h01;
            end
            ppses_pkg::type_retry_sym: begin
                if (sym_ok && sym_retry) inc = 7'h01;
            end
            ppses_pkg::type_other_sym: begin
                if (sym_ok && !sym_retry) inc = 7'h01;
            end
            ppses_pkg::type_uni_words: begin
                if (uni_ok) inc = pkt_words;
            end
            ppses_pkg::type_mc_pkt: begin
                if (mc_ok) inc = 7'h01;
            end
            ppses_pkg::type_mc_sym: begin
                if (sym_ok && sym_multicast) inc = 7'h01;
            end
            ppses_pkg::type_mc_words: begin
                if (mc_ok) inc = pkt_words;
            end
            default: inc = 7'h00;
        endcase
    end

endmodule

// ### ppses_pkg.sv
// Purpose: Types shared by the event select block
// Assumes: Constants come from the defs header
// Notes:   Event type codes follow the 3-bit type field
`include "ppses_defs.svh"

package ppses_pkg;

    typedef enum logic [2:0] {
        type_uni_req   = 3'h0,
        type_uni_all   = 3'h1,
        type_retry_sym = 3'h2,
        type_other_sym = 3'h3,
        type_uni_words = 3'h4,
        type_mc_pkt    = 3'h5,
        type_mc_sym    = 3'h6,
        type_mc_words  = 3'h7
    } ppses_type_e;

    typedef struct packed {
        logic [`PPSES_DATA_W-1:0]           ctrl;
        logic [1:0][`PPSES_INC_W-1:0]       inc;
        logic [`PPSES_DATA_W-1:0]           rd_data;
    } ppses_top_s;

    typedef struct packed {
        logic [`PPSES_DATA_W-1:0]           count;
    } ppses_accum_s;

endpackage

// ### ppses_top.sv
// Purpose: Per-port event selection and accumulation for statistics counters 2 and 3
// Assumes: Event inputs synchronous to clk; register port never waits
// Notes:   Control word holds type, priority and direction for both counters
// Function
// - Type 000 counts unicast non-maintenance requests only
// - Type 001 counts every unicast packet
// - Type 010 counts retry control symbols only
// - Type 011 counts non-retry control symbols
// - Type 100 adds unicast 32-bit words
// - Type 101 counts multicast packets only
// - Type 110 counts multicast control symbols
// - Type 111 adds multicast 32-bit words
// - Retried traffic never counts
// - Counter 2 type is bits 15:13, reset zero
// - Bits 16-18 select counter 3 priorities 3-1
// - No priority selected disables the counter
// - All priorities selected counts every priority
// - Direction bit: zero receive, one transmit
//
// Chosen here: the register offsets and strobed register access.
`timescale 1ns/1ps
`include "ppses_defs.svh"

module ppses_top (
    input  wire logic                     clk,
    input  wire logic                     nrst,
    input  wire logic                     ce,
    input  wire logic [`PPSES_ADDR_W-1:0] addr,
    input  wire logic [`PPSES_DATA_W-1:0] wr_data,
    input  wire logic                     wr_en,
    input  wire logic                     rd_en,
    output logic      [`PPSES_DATA_W-1:0] rd_data,
    input  wire logic                     pkt_valid,
    input  wire logic                     pkt_dir,
    input  wire logic [1:0]               pkt_prio,
    input  wire logic                     pkt_multicast,
    input  wire logic                     pkt_request,
    input  wire logic                     pkt_maint,
    input  wire logic                     pkt_retried,
    input  wire logic [`PPSES_INC_W-1:0]  pkt_words,
    input  wire logic                     sym_valid,
    input  wire logic                     sym_dir,
    input  wire logic                     sym_retry,
    input  wire logic                     sym_multicast,
    output logic      [`PPSES_DATA_W-1:0] ctr2_count,
    output logic      [`PPSES_DATA_W-1:0] ctr3_count
);

    ppses_pkg::ppses_top_s                st_ff;
    ppses_pkg::ppses_top_s                nxt_st;
    logic [1:0][`PPSES_INC_W-1:0]         inc_w;
    logic [1:0][`PPSES_DATA_W-1:0]        count_w;
    logic [1:0][`PPSES_TYPE_W-1:0]        cfg_type;
    logic [1:0][3:0]                      cfg_prio;
    logic [1:0]                           cfg_dir;
    logic [1:0]                           load_w;
    logic                                 ctrl_wr;

    assign ctrl_wr = wr_en && (addr == `PPSES_CTRL_OFS);

    genvar k;
    generate
        for (k = 0; k < 2; k = k + 1) begin : g_ctr
            localparam int BASE = k * `PPSES_CTR_STRIDE;
            localparam logic [`PPSES_ADDR_W-1:0] OFS = (k == 0) ? `PPSES_CTR2_OFS
                                                                : `PPSES_CTR3_OFS;

            // Field extraction from the shared control word
            assign cfg_type[k] = st_ff.ctrl[BASE + `PPSES_TYPE_LSB +: `PPSES_TYPE_W];
            assign cfg_prio[k] = {st_ff.ctrl[BASE + `PPSES_PRIO3_POS],
                                  st_ff.ctrl[BASE + `PPSES_PRIO2_POS],
                                  st_ff.ctrl[BASE + `PPSES_PRIO1_POS],
                                  st_ff.ctrl[BASE + `PPSES_PRIO0_POS]};
            assign cfg_dir[k]  = st_ff.ctrl[BASE + `PPSES_DIR_POS];
            assign load_w[k]   = ce && wr_en && (addr == OFS);

            ppses_match u_match (
                .ev_type       (cfg_type[k]),
                .prio_sel      (cfg_prio[k]),
                .dir_sel       (cfg_dir[k]),
                .pkt_valid     (pkt_valid),
                .pkt_dir       (pkt_dir),
                .pkt_prio      (pkt_prio),
                .pkt_multicast (pkt_multicast),
                .pkt_request   (pkt_request),
                .pkt_maint     (pkt_maint),
                .pkt_retried   (pkt_retried),
                .pkt_words     (pkt_words),
                .sym_valid     (sym_valid),
                .sym_dir       (sym_dir),
                .sym_retry     (sym_retry),
                .sym_multicast (sym_multicast),
                .inc           (inc_w[k])
            );

            ppses_accum u_accum (
                .clk       (clk),
                .nrst      (nrst),
                .ce        (ce),
                .load      (load_w[k]),
                .load_data (wr_data),
                .inc       (st_ff.inc[k]),
                .count     (count_w[k])
            );
        end
    endgenerate

    always_comb begin
        nxt_st         = st_ff;
        nxt_st.inc     = inc_w;
        nxt_st.rd_data = 32'h0000_0000;
        // Reserved bits are kept at zero so they read back as zero
        if (ctrl_wr) begin
            nxt_st.ctrl = wr_data & `PPSES_CTRL_MASK;
        end
        if (rd_en) begin
            if (addr == `PPSES_CTRL_OFS) begin
                nxt_st.rd_data = st_ff.ctrl;
            end else if (addr == `PPSES_CTR2_OFS) begin
                nxt_st.rd_data = count_w[0];
            end else if (addr == `PPSES_CTR3_OFS) begin
                nxt_st.rd_data = count_w[1];
            end else begin
                nxt_st.rd_data = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_ff.ctrl    <= `PPSES_CTRL_RST;
            st_ff.inc     <= '0;
            st_ff.rd_data <= 32'h0000_0000;
        end else if (ce) begin
            st_ff <= nxt_st;
        end
    end

    assign rd_data    = st_ff.rd_data;
    assign ctr2_count = count_w[0];
    assign ctr3_count = count_w[1];

    // Checks on counter 2 selection, counter 3 gating, the control word and the read slot

    uni_req_count_a: assert property (@(posedge clk) disable iff (!nrst)
        ce && cfg_type[0] == 3'h0 && pkt_valid && !pkt_retried && pkt_dir == cfg_dir[0]
        && cfg_prio[0][pkt_prio] && !pkt_multicast && pkt_request && !pkt_maint
        |=> st_ff.inc[0] == 7'h01)
        else $error("unicast request not counted");

    uni_req_excl_a: assert property (@(posedge clk) disable iff (!nrst)
        ce && cfg_type[0] == 3'h0 && (!pkt_request || pkt_maint || pkt_multicast)
        |=> st_ff.inc[0] == 7'h00)
        else $error("response or maintenance packet counted as request");

    uni_all_a: assert property (@(posedge clk) disable iff (!nrst)
        ce && cfg_type[0] == 3'h1 && pkt_valid && !pkt_retried && pkt_dir == cfg_dir[0]
        && cfg_prio[0][pkt_prio] && !pkt_multicast
        |=> st_ff.inc[0] == 7'h01)
        else $error("unicast packet not counted");

    retry_sym_a: assert property (@(posedge clk) disable iff (!nrst)
        ce && cfg_type[0] == 3'h2
        |=> st_ff.inc[0] == {6'h00, $past(sym_valid && sym_retry && sym_dir == cfg_dir[0]
                                       && (|cfg_prio[0]))})
        else $error("retry symbol count wrong");

    other_sym_a: assert property (@(posedge clk) disable iff (!nrst)
        ce && cfg_type[0] == 3'h3
        |=> st_ff.inc[0] == {6'h00, $past(sym_valid && !sym_retry && sym_dir == cfg_dir[0]
                                       && (|cfg_prio[0]))})
        else $error("non-retry symbol count wrong");

    uni_words_a: assert property (@(posedge clk) disable iff (!nrst)
        ce && cfg_type[0] == 3'h4 && pkt_valid && !pkt_retried && pkt_dir == cfg_dir[0]
        && cfg_prio[0][pkt_prio] && !pkt_multicast
        |=> st_ff.inc[0] == $past(pkt_words))
        else $error("unicast word count wrong");

    mc_pkt_a: assert property (@(posedge clk) disable iff (!nrst)
        ce && cfg_type[0] == 3'h5 && (!pkt_multicast || !pkt_valid)
        |=> st_ff.inc[0] == 7'h00)
        else $error("non-multicast event counted as multicast packet");

    mc_sym_a: assert property (@(posedge clk) disable iff (!nrst)
        ce && cfg_type[0] == 3'h6 && sym_valid && sym_multicast && sym_dir == cfg_dir[0]
        && (|cfg_prio[0])
        |=> st_ff.inc[0] == 7'h01)
        else $error("multicast symbol not counted");

    mc_words_a: assert property (@(posedge clk) disable iff (!nrst)
        ce && cfg_type[0] == 3'h7 && pkt_valid && !pkt_retried && pkt_dir == cfg_dir[0]
        && cfg_prio[0][pkt_prio] && pkt_multicast
        |=> st_ff.inc[0] == $past(pkt_words))
        else $error("multicast word count wrong");

    retried_excl_a: assert property (@(posedge clk) disable iff (!nrst)
        ce && pkt_retried && !sym_valid
        |=> st_ff.inc[0] == 7'h00 && st_ff.inc[1] == 7'h00)
        else $error("retried packet counted");

    ctrl_type_rw_a: assert property (@(posedge clk) disable iff (!nrst)
        ce && ctrl_wr
        |=> cfg_type[0] == $past(wr_data[`PPSES_TYPE_LSB +: `PPSES_TYPE_W]))
        else $error("counter 2 type field did not take the write");

    ctr3_prio_rw_a: assert property (@(posedge clk) disable iff (!nrst)
        ce && ctrl_wr
        |=> cfg_prio[1][3:1] == {$past(wr_data[16]), $past(wr_data[17]), $past(wr_data[18])})
        else $error("counter 3 priority selects did not take the write");

    ctr3_off_a: assert property (@(posedge clk) disable iff (!nrst)
        ce && cfg_prio[1] == 4'h0
        |=> st_ff.inc[1] == 7'h00)
        else $error("counter 3 counted with no priority selected");

    all_prio_a: assert property (@(posedge clk) disable iff (!nrst)
        ce && cfg_prio[0] == 4'hF && cfg_type[0] == 3'h1 && pkt_valid && !pkt_retried
        && !pkt_multicast && pkt_dir == cfg_dir[0]
        |=> st_ff.inc[0] == 7'h01)
        else $error("packet missed with all priorities selected");

    dir_mismatch_a: assert property (@(posedge clk) disable iff (!nrst)
        ce && !sym_valid && pkt_dir != cfg_dir[0]
        |=> st_ff.inc[0] == 7'h00)
        else $error("packet of the other direction counted");

    read_slot_a: assert property (@(posedge clk) disable iff (!nrst)
        ce && !rd_en |=> rd_data == 32'h0000_0000)
        else $error("read data outside its slot");

    // Exclusions, counter 3 gating and read-back

    uni_all_excl_a: assert property (@(posedge clk) disable iff (!nrst)
        ce && cfg_type[0] == 3'h1 && (pkt_multicast || !pkt_valid)
        |=> st_ff.inc[0] == 7'h00)
        else $error("non-unicast event counted");

    uni_words_excl_a: assert property (@(posedge clk) disable iff (!nrst)
        ce && cfg_type[0] == 3'h4 && (pkt_multicast || pkt_retried || !pkt_valid)
        |=> st_ff.inc[0] == 7'h00)
        else $error("unicast words added wrongly");

    mc_sym_excl_a: assert property (@(posedge clk) disable iff (!nrst)
        ce && cfg_type[0] == 3'h6 && !(sym_valid && sym_multicast)
        |=> st_ff.inc[0] == 7'h00)
        else $error("non-multicast symbol counted");

    mc_words_excl_a: assert property (@(posedge clk) disable iff (!nrst)
        ce && cfg_type[0] == 3'h7 && (!pkt_multicast || pkt_retried || !pkt_valid)
        |=> st_ff.inc[0] == 7'h00)
        else $error("multicast words added wrongly");

    prio_mask_a: assert property (@(posedge clk) disable iff (!nrst)
        ce && !sym_valid && !cfg_prio[0][pkt_prio]
        |=> st_ff.inc[0] == 7'h00)
        else $error("unselected priority counted");

    ctr2_off_a: assert property (@(posedge clk) disable iff (!nrst)
        ce && cfg_prio[0] == 4'h0
        |=> st_ff.inc[0] == 7'h00)
        else $error("counter 2 counted while disabled");

    ctr3_uni_a: assert property (@(posedge clk) disable iff (!nrst)
        ce && cfg_type[1] == 3'h1 && pkt_valid && !pkt_retried && !pkt_multicast
        && pkt_dir == cfg_dir[1] && cfg_prio[1][pkt_prio]
        |=> st_ff.inc[1] == 7'h01)
        else $error("counter 3 missed a packet");

    ctr3_mask_a: assert property (@(posedge clk) disable iff (!nrst)
        ce && !sym_valid && !cfg_prio[1][pkt_prio]
        |=> st_ff.inc[1] == 7'h00)
        else $error("counter 3 unselected priority");

    ctr3_dir_a: assert property (@(posedge clk) disable iff (!nrst)
        ce && !sym_valid && pkt_dir != cfg_dir[1]
        |=> st_ff.inc[1] == 7'h00)
        else $error("counter 3 other direction");

    ctrl_read_a: assert property (@(posedge clk) disable iff (!nrst)
        ce && rd_en && addr == `PPSES_CTRL_OFS
        |=> rd_data == $past(st_ff.ctrl))
        else $error("control word read wrong");

    ctr2_read_a: assert property (@(posedge clk) disable iff (!nrst)
        ce && rd_en && addr == `PPSES_CTR2_OFS
        |=> rd_data == $past(ctr2_count))
        else $error("counter 2 read wrong");

    uni_req_c: cover property (@(posedge clk) disable iff (!nrst)
        ce && cfg_type[0] == 3'h0 ##1 st_ff.inc[0] == 7'h01);

    words_c: cover property (@(posedge clk) disable iff (!nrst)
        ce && cfg_type[0] == 3'h4 ##1 st_ff.inc[0] > 7'h01);

    ctr3_inc_c: cover property (@(posedge clk) disable iff (!nrst)
        st_ff.inc[1] != 7'h00);

    ctrl_rd_c: cover property (@(posedge clk) disable iff (!nrst)
        ce && ctrl_wr ##1 ce && rd_en && addr == `PPSES_CTRL_OFS);

    mc_words_c: cover property (@(posedge clk) disable iff (!nrst)
        ce && cfg_type[0] == 3'h7 ##1 st_ff.inc[0] > 7'h01);

endmodule

// ### ppses_top_tb.sv
// Purpose: Self-checking bench for the statistics event select block
// Assumes: Offsets from the defs header, field positions coded by hand in ctl; one event pulse per row
// Notes:   Counters are cleared by software before every row, so expected count = increment
`timescale 1ns/1ps
`include "ppses_defs.svh"

module ppses_top_tb;

    typedef struct packed {
        logic [31:0] ctrl;
        logic [7:0]  pk;
        logic [6:0]  words;
        logic [3:0]  sy;
        logic [31:0] e2;
        logic [31:0] e3;
    } ppses_row_s;

    logic        clk;
    logic        nrst;
    logic        ce;
    logic [15:0] addr;
    logic [31:0] wr_data;
    logic        wr_en;
    logic        rd_en;
    logic [31:0] rd_data;
    logic        pkt_valid;
    logic        pkt_dir;
    logic [1:0]  pkt_prio;
    logic        pkt_multicast;
    logic        pkt_request;
    logic        pkt_maint;
    logic        pkt_retried;
    logic [6:0]  pkt_words;
    logic        sym_valid;
    logic        sym_dir;
    logic        sym_retry;
    logic        sym_multicast;
    logic [31:0] ctr2_count;
    logic [31:0] ctr3_count;
    int          n_fail;
    int          checks_done;
    int          cycles;
    ppses_row_s  rows[$];

    ppses_top u_dut (
        .clk(clk), .nrst(nrst), .ce(ce), .addr(addr), .wr_data(wr_data),
        .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .pkt_valid(pkt_valid),
        .pkt_dir(pkt_dir), .pkt_prio(pkt_prio), .pkt_multicast(pkt_multicast),
        .pkt_request(pkt_request), .pkt_maint(pkt_maint), .pkt_retried(pkt_retried),
        .pkt_words(pkt_words), .sym_valid(sym_valid), .sym_dir(sym_dir),
        .sym_retry(sym_retry), .sym_multicast(sym_multicast),
        .ctr2_count(ctr2_count), .ctr3_count(ctr3_count)
    );

    always #5 clk = ~clk;

    task automatic stop_test();
        if (n_fail == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            n_fail++;
            stop_test();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Mask bit p selects priority p; field holds prio3 at its lowest bit
    function automatic logic [31:0] ctl(input logic [2:0] t2, input logic [3:0] m2,
                                        input logic d2, input logic [2:0] t3,
                                        input logic [3:0] m3, input logic d3);
        ctl = {t3, 5'h00, d3, 3'h0, m3[0], m3[1], m3[2], m3[3],
               t2, 5'h00, d2, 3'h0, m2[0], m2[1], m2[2], m2[3]};
    endfunction

    function automatic logic [7:0] pk(input logic v, input logic d, input logic [1:0] pri,
                                      input logic mc, input logic rq, input logic mt,
                                      input logic rt);
        pk = {v, d, pri, mc, rq, mt, rt};
    endfunction

    function automatic logic [3:0] sy(input logic v, input logic d, input logic r,
                                      input logic m);
        sy = {v, d, r, m};
    endfunction

    task automatic add(input logic [31:0] c, input logic [7:0] p, input logic [6:0] w,
                       input logic [3:0] s, input logic [31:0] e2, input logic [31:0] e3);
        rows.push_back({c, p, w, s, e2, e3});
    endtask

    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge clk);
        wr_en   <= 1'b1;
        addr    <= a;
        wr_data <= d;
        @(posedge clk);
        wr_en   <= 1'b0;
    endtask

    task automatic rd(input logic [15:0] a, output logic [31:0] d);
        @(posedge clk);
        rd_en <= 1'b1;
        addr  <= a;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 d = rd_data;
    endtask

    task automatic ev(input logic [7:0] p, input logic [6:0] w, input logic [3:0] s);
        @(posedge clk);
        {pkt_valid, pkt_dir, pkt_prio, pkt_multicast, pkt_request, pkt_maint,
         pkt_retried} <= p;
        pkt_words <= w;
        {sym_valid, sym_dir, sym_retry, sym_multicast} <= s;
        @(posedge clk);
        pkt_valid <= 1'b0;
        sym_valid <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask

    logic [31:0] v;

    initial begin
        clk = 1'b0; nrst = 1'b0; ce = 1'b1; addr = 16'h0000; wr_data = 32'h0000_0000;
        wr_en = 1'b0; rd_en = 1'b0; pkt_valid = 1'b0; pkt_dir = 1'b0; pkt_prio = 2'h0;
        pkt_multicast = 1'b0; pkt_request = 1'b0; pkt_maint = 1'b0; pkt_retried = 1'b0;
        pkt_words = 7'h00; sym_valid = 1'b0; sym_dir = 1'b0; sym_retry = 1'b0;
        sym_multicast = 1'b0; n_fail = 0; checks_done = 0; cycles = 0;
        // Type rows: counter 3 counts all unicast packets as a reference
        add(ctl(0, 15, 0, 1, 15, 0), pk(1, 0, 2, 0, 1, 0, 0), 5, 0, 1, 1);
        add(ctl(0, 15, 0, 1, 15, 0), pk(1, 0, 2, 0, 1, 1, 0), 5, 0, 0, 1);
        add(ctl(0, 15, 0, 1, 15, 0), pk(1, 0, 1, 0, 0, 0, 0), 5, 0, 0, 1);
        add(ctl(1, 15, 0, 1, 15, 0), pk(1, 0, 0, 0, 0, 1, 0), 5, 0, 1, 1);
        add(ctl(1, 15, 0, 1, 15, 0), pk(1, 0, 3, 1, 1, 0, 0), 5, 0, 0, 0);
        add(ctl(2, 15, 0, 1, 15, 0), pk(1, 0, 0, 0, 1, 0, 0), 5, sy(1, 0, 1, 0), 1, 1);
        add(ctl(2, 15, 0, 1, 15, 0), 0, 5, sy(1, 0, 0, 0), 0, 0);
        add(ctl(3, 15, 0, 1, 15, 0), 0, 5, sy(1, 0, 0, 0), 1, 0);
        add(ctl(3, 15, 0, 1, 15, 0), 0, 5, sy(1, 0, 1, 0), 0, 0);
        add(ctl(3, 15, 1, 1, 15, 0), 0, 5, sy(1, 0, 0, 0), 0, 0);
        add(ctl(3, 15, 1, 1, 15, 0), 0, 5, sy(1, 1, 0, 0), 1, 0);
        add(ctl(4, 15, 0, 1, 15, 0), pk(1, 0, 1, 0, 1, 0, 0), 9, 0, 9, 1);
        add(ctl(4, 15, 0, 1, 15, 0), pk(1, 0, 1, 1, 1, 0, 0), 9, 0, 0, 0);
        add(ctl(5, 15, 0, 1, 15, 0), pk(1, 0, 1, 1, 1, 0, 0), 9, 0, 1, 0);
        add(ctl(5, 15, 0, 1, 15, 0), pk(1, 0, 1, 0, 1, 0, 0), 9, 0, 0, 1);
        add(ctl(6, 15, 0, 1, 15, 0), 0, 9, sy(1, 0, 0, 1), 1, 0);
        add(ctl(6, 15, 0, 1, 15, 0), 0, 9, sy(1, 0, 0, 0), 0, 0);
        add(ctl(7, 15, 0, 1, 15, 0), pk(1, 0, 0, 1, 0, 0, 0), 12, 0, 12, 0);
        add(ctl(7, 15, 0, 1, 15, 0), pk(1, 0, 0, 0, 0, 0, 0), 12, 0, 0, 1);
        add(ctl(1, 15, 0, 1, 15, 0), pk(1, 0, 2, 0, 1, 0, 1), 5, 0, 0, 0);
        add(ctl(4, 15, 0, 1, 15, 0), pk(1, 0, 2, 0, 1, 0, 1), 5, 0, 0, 0);
        add(ctl(2, 15, 0, 1, 15, 0), pk(1, 0, 2, 0, 1, 0, 1), 5, sy(1, 0, 1, 0), 1, 0);
        add(ctl(1, 15, 1, 1, 15, 1), pk(1, 0, 2, 0, 1, 0, 0), 5, 0, 0, 0);
        add(ctl(1, 15, 1, 1, 15, 0), pk(1, 1, 2, 0, 1, 0, 0), 5, 0, 1, 0);
        add(ctl(1, 1, 0, 1, 8, 0), pk(1, 0, 3, 0, 1, 0, 0), 5, 0, 0, 1);
        add(ctl(1, 8, 0, 1, 4, 0), pk(1, 0, 2, 0, 1, 0, 0), 5, 0, 0, 1);
        add(ctl(1, 4, 0, 1, 2, 0), pk(1, 0, 1, 0, 1, 0, 0), 5, 0, 0, 1);
        add(ctl(1, 1, 0, 1, 2, 0), pk(1, 0, 0, 0, 1, 0, 0), 5, 0, 1, 0);
        add(ctl(1, 15, 0, 1, 0, 0), pk(1, 0, 0, 0, 1, 0, 0), 5, 0, 1, 0);
        add(ctl(1, 0, 0, 1, 0, 0), pk(1, 0, 3, 0, 1, 0, 0), 5, 0, 0, 0);
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        rd(`PPSES_CTRL_OFS, v);
        chk(v, 32'h0000_0000);
        chk(ctr2_count, 32'h0000_0000);
        foreach (rows[i]) begin
            wr(`PPSES_CTRL_OFS, rows[i].ctrl);
            wr(`PPSES_CTR2_OFS, 32'h0000_0000);
            wr(`PPSES_CTR3_OFS, 32'h0000_0000);
            rd(`PPSES_CTRL_OFS, v);
            chk(v, rows[i].ctrl);
            ev(rows[i].pk, rows[i].words, rows[i].sy);
            chk(ctr2_count, rows[i].e2);
            chk(ctr3_count, rows[i].e3);
        end
        // Write then read with no gap; reserved bits drop, data stands one cycle
        @(posedge clk);
        wr_en   <= 1'b1;
        addr    <= `PPSES_CTRL_OFS;
        wr_data <= 32'hFFFF_FFFF;
        @(posedge clk);
        wr_en <= 1'b0;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 chk(rd_data, 32'hE08F_E08F);
        @(posedge clk);
        #1 chk(rd_data, 32'h0000_0000);
        rd(16'h0030, v);
        chk(v, 32'h0000_0000);
        // Strobe while frozen is lost
        @(posedge clk);
        ce <= 1'b0;
        wr(`PPSES_CTRL_OFS, ctl(1, 15, 0, 1, 15, 0));
        ce <= 1'b1;
        rd(`PPSES_CTRL_OFS, v);
        chk(v, 32'hE08F_E08F);
        // Back-to-back packets across the counter wrap
        wr(`PPSES_CTRL_OFS, ctl(1, 15, 0, 1, 15, 0));
        wr(`PPSES_CTR2_OFS, 32'hFFFF_FFFE);
        @(posedge clk);
        {pkt_valid, pkt_dir, pkt_prio, pkt_multicast, pkt_request, pkt_maint,
         pkt_retried} <= pk(1, 0, 1, 0, 0, 0, 0);
        repeat (3) @(posedge clk);
        pkt_valid <= 1'b0;
        repeat (2) @(posedge clk);
        rd(`PPSES_CTR2_OFS, v);
        chk(v, 32'h0000_0001);
        chk(ctr3_count, 32'h0000_0003);
        // Reset in mid-run clears the control word and counters
        @(posedge clk);
        nrst <= 1'b0;
        @(posedge clk);
        #1 chk(ctr3_count, 32'h0000_0000);
        @(posedge clk);
        nrst <= 1'b1;
        rd(`PPSES_CTRL_OFS, v);
        chk(v, 32'h0000_0000);
        stop_test();
    end

endmodule
